// file: logic/fla_regs.vh
// register offsets, field positions, reset values and timing counts for the linear access block
`ifndef FLA_REGS_VH
`define FLA_REGS_VH
`define FLA_ADDR_W      4
`define FLA_PTR_W       17
`define FLA_OFF_PTR2    4'h0
`define FLA_OFF_PTR1    4'h1
`define FLA_OFF_PTR0    4'h2
`define FLA_OFF_WORDP   4'h3
`define FLA_OFF_BYTEP   4'h4
`define FLA_OFF_PLAIN   4'h5
`define FLA_OFF_ADD     4'h6
`define FLA_OFF_CLKDIV  4'h8
`define FLA_OFF_CTRL    4'h9
`define FLA_OFF_CMD     4'hA
`define FLA_OFF_STAT    4'hB
`define FLA_PTR_RST     17'h0_0000
`define FLA_DIV_RST     8'h00
`define FLA_CTRL_RST    8'h00
`define FLA_CTRL_EE     0
`define FLA_CTRL_EE8    1
`define FLA_ST_ERR      0
`define FLA_ST_DONE     1
`define FLA_ST_BUSY     2
`define FLA_ST_LOADED   3
`define FLA_CMD_BLANK   8'h05
`define FLA_CMD_BYTE    8'h20
`define FLA_CMD_BURST   8'h25
`define FLA_CMD_SECT    8'h40
`define FLA_CMD_MASS    8'h41
`define FLA_CMD_ABORT   8'h47
`define FLA_CYC_BYTE    15'h0009
`define FLA_CYC_BURST   15'h0004
`define FLA_CYC_SECT    15'h0FA0
`define FLA_CYC_MASS    15'h4E20
`define FLA_CYC_ABORT   15'h0004
`define FLA_CYC_BLANK   15'h0004
`define FLA_FL_SECT_W   9
`endif

// file: logic/fla_linear_access.v
// linear pointer data ports, write-once timing divider and program/erase timing sequencer
`include "fla_regs.vh"

module fla_linear_access (
    // clock and reset
    input  wire         clk,
    input  wire         reset_n,
    // cpu register access
    input  wire [3:0]   cpu_addr,
    input  wire         cpu_wr,
    input  wire         cpu_rd,
    input  wire [7:0]   cpu_wdata,
    output reg  [7:0]   cpu_rdata_q,
    // memory array access
    input  wire [7:0]   mem_rdata,
    output wire [16:0]  mem_addr,
    output reg  [7:0]   mem_wdata_q,
    output reg          mem_wr_q,
    // nonvolatile sequencer side
    output reg          nvm_timing_tick_q,
    output reg          nvm_hv_on_q,
    output reg  [7:0]   nvm_op_q,
    output reg  [16:0]  nvm_sector_q,
    output reg          nvm_eeprom_q
);

    // one-hot sequencer states
    localparam ST_IDLE = 2'b01;
    localparam ST_RUN  = 2'b10;

    // pointer state
    reg  [16:0] linear_pointer_q;
    reg  [16:0] linear_pointer_d;

    // divider and timing enable state
    reg  [7:0]  nvm_clock_divider_q;
    reg         div_loaded_q;
    reg  [7:0]  div_cnt_q;

    // sequencer state and flags
    reg  [7:0]  ctrl_q;
    reg  [1:0]  state_q;
    reg  [14:0] cyc_left_q;
    reg         access_error_flag_q;
    reg         done_q;
    reg         abort_pend_q;
    reg         chain_q;
    reg  [16:0] last_addr_q;

    // register decodes
    wire        sel_ptr2  = (cpu_addr == `FLA_OFF_PTR2);
    wire        sel_ptr1  = (cpu_addr == `FLA_OFF_PTR1);
    wire        sel_ptr0  = (cpu_addr == `FLA_OFF_PTR0);
    wire        sel_wordp = (cpu_addr == `FLA_OFF_WORDP);
    wire        sel_bytep = (cpu_addr == `FLA_OFF_BYTEP);
    wire        sel_plain = (cpu_addr == `FLA_OFF_PLAIN);
    wire        sel_add   = (cpu_addr == `FLA_OFF_ADD);
    wire        sel_div   = (cpu_addr == `FLA_OFF_CLKDIV);
    wire        sel_ctrl  = (cpu_addr == `FLA_OFF_CTRL);
    wire        sel_cmd   = (cpu_addr == `FLA_OFF_CMD);
    wire        sel_stat  = (cpu_addr == `FLA_OFF_STAT);

    // access classes, busy, timing enable and strobes
    wire        post_inc  = sel_wordp | sel_bytep;
    wire        data_port = post_inc | sel_plain;
    wire        busy      = state_q[1];
    wire        tick      = div_loaded_q && (div_cnt_q == nvm_clock_divider_q);
    wire        cmd_wr    = cpu_wr && sel_cmd;
    wire        stat_wr   = cpu_wr && sel_stat;

    // the pointer drives the array address directly
    assign mem_addr = linear_pointer_q;

    // next pointer: byte writes, signed add, post increment, wrapping at 17 bits
    always @* begin
        linear_pointer_d = linear_pointer_q;
        if (cpu_wr && sel_ptr2) begin
            linear_pointer_d[16] = cpu_wdata[0];
        end else if (cpu_wr && sel_ptr1) begin
            linear_pointer_d[15:8] = cpu_wdata;
        end else if (cpu_wr && sel_ptr0) begin
            linear_pointer_d[7:0] = cpu_wdata;
        end else if (cpu_wr && sel_add) begin
            linear_pointer_d = linear_pointer_q + {{9{cpu_wdata[7]}}, cpu_wdata};
        end else if ((cpu_wr || cpu_rd) && post_inc) begin
            linear_pointer_d = linear_pointer_q + 17'h0_0001;
        end
    end

    // pointer register
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            linear_pointer_q <= `FLA_PTR_RST;
        end else begin
            linear_pointer_q <= linear_pointer_d;
        end
    end

    // writes through any data port go to the array at the current pointer
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_wr_q    <= 1'b0;
            mem_wdata_q <= 8'h00;
        end else begin
            mem_wr_q <= cpu_wr && data_port;
            if (cpu_wr && data_port) begin
                mem_wdata_q <= cpu_wdata;
            end
        end
    end

    // status byte as software reads it
    reg [7:0] stat_rd;
    always @* begin
        stat_rd                 = 8'h00;
        stat_rd[`FLA_ST_ERR]    = access_error_flag_q;
        stat_rd[`FLA_ST_DONE]   = done_q;
        stat_rd[`FLA_ST_BUSY]   = busy;
        stat_rd[`FLA_ST_LOADED] = div_loaded_q;
    end

    // read data, sampled with the pointer before it moves
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cpu_rdata_q <= 8'h00;
        end else if (cpu_rd) begin
            if (data_port) begin
                cpu_rdata_q <= mem_rdata;
            end else if (sel_ptr2) begin
                cpu_rdata_q <= {7'h00, linear_pointer_q[16]};
            end else if (sel_ptr1) begin
                cpu_rdata_q <= linear_pointer_q[15:8];
            end else if (sel_ptr0) begin
                cpu_rdata_q <= linear_pointer_q[7:0];
            end else if (sel_div) begin
                cpu_rdata_q <= nvm_clock_divider_q;
            end else if (sel_ctrl) begin
                cpu_rdata_q <= ctrl_q;
            end else if (sel_cmd) begin
                cpu_rdata_q <= nvm_op_q;
            end else if (sel_stat) begin
                cpu_rdata_q <= stat_rd;
            end else begin
                cpu_rdata_q <= 8'h00;
            end
        end
    end

    // write-once divider; later writes are dropped
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            nvm_clock_divider_q <= `FLA_DIV_RST;
            div_loaded_q        <= 1'b0;
        end else if (cpu_wr && sel_div && !div_loaded_q) begin
            nvm_clock_divider_q <= cpu_wdata;
            div_loaded_q        <= 1'b1;
        end
    end

    // timing clock enable: one tick every divider+1 bus cycles
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_cnt_q         <= 8'h00;
            nvm_timing_tick_q <= 1'b0;
        end else begin
            nvm_timing_tick_q <= tick;
            if (!div_loaded_q || tick) begin
                div_cnt_q <= 8'h00;
            end else begin
                div_cnt_q <= div_cnt_q + 8'h01;
            end
        end
    end

    // sector selection register
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= `FLA_CTRL_RST;
        end else if (cpu_wr && sel_ctrl) begin
            ctrl_q <= {6'h00, cpu_wdata[1:0]};
        end
    end

    // command launch checks
    wire cmd_valid = (cpu_wdata == `FLA_CMD_BLANK) || (cpu_wdata == `FLA_CMD_BYTE)
                   || (cpu_wdata == `FLA_CMD_BURST) || (cpu_wdata == `FLA_CMD_SECT)
                   || (cpu_wdata == `FLA_CMD_MASS) || (cpu_wdata == `FLA_CMD_ABORT);
    wire is_abort  = (cpu_wdata == `FLA_CMD_ABORT);
    wire abort_hit = busy && is_abort && (nvm_op_q == `FLA_CMD_SECT) && !abort_pend_q;
    wire reject    = cmd_wr && (!div_loaded_q || !cmd_valid || access_error_flag_q
                                || (busy && !abort_hit));

    // launch, burst chaining and completion
    wire start     = cmd_wr && !reject && !busy;
    wire chained   = chain_q && (linear_pointer_q == last_addr_q + 17'h0_0001)
                   && (linear_pointer_q[16:5] == last_addr_q[16:5]);
    wire finish    = busy && tick && (cyc_left_q == 15'h0001);

    // cycle count of the command about to start
    reg [14:0] cyc_load;
    always @* begin
        case (cpu_wdata)
            `FLA_CMD_BYTE:  cyc_load = `FLA_CYC_BYTE;
            `FLA_CMD_BURST: cyc_load = chained ? `FLA_CYC_BURST : `FLA_CYC_BYTE;
            `FLA_CMD_SECT:  cyc_load = `FLA_CYC_SECT;
            `FLA_CMD_MASS:  cyc_load = `FLA_CYC_MASS;
            `FLA_CMD_ABORT: cyc_load = `FLA_CYC_ABORT;
            default:        cyc_load = `FLA_CYC_BLANK;
        endcase
    end

    // erase sector base: 512-byte flash, 4- or 8-byte eeprom
    reg [16:0] sect_base;
    always @* begin
        if (!ctrl_q[`FLA_CTRL_EE]) begin
            sect_base = {linear_pointer_q[16:`FLA_FL_SECT_W], 9'h000};
        end else if (ctrl_q[`FLA_CTRL_EE8]) begin
            sect_base = {linear_pointer_q[16:3], 3'h0};
        end else begin
            sect_base = {linear_pointer_q[16:2], 2'h0};
        end
    end

    // sequencer: counts whole timing ticks per command
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q      <= ST_IDLE;
            cyc_left_q   <= 15'h0000;
            nvm_hv_on_q  <= 1'b0;
            nvm_op_q     <= 8'h00;
            nvm_sector_q <= 17'h0_0000;
            nvm_eeprom_q <= 1'b0;
            abort_pend_q <= 1'b0;
            chain_q      <= 1'b0;
            last_addr_q  <= 17'h0_0000;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        state_q      <= ST_RUN;
                        cyc_left_q   <= cyc_load;
                        nvm_hv_on_q  <= !is_abort && (cpu_wdata != `FLA_CMD_BLANK);
                        nvm_op_q     <= cpu_wdata;
                        nvm_sector_q <= sect_base;
                        nvm_eeprom_q <= ctrl_q[`FLA_CTRL_EE];
                        chain_q      <= 1'b0;
                        last_addr_q  <= linear_pointer_q;
                    end
                end
                ST_RUN: begin
                    if (abort_hit && cmd_wr && !access_error_flag_q) begin
                        cyc_left_q   <= `FLA_CYC_ABORT;
                        abort_pend_q <= 1'b1;
                    end else if (finish) begin
                        state_q      <= ST_IDLE;
                        nvm_hv_on_q  <= 1'b0;
                        abort_pend_q <= 1'b0;
                        chain_q      <= (nvm_op_q == `FLA_CMD_BURST);
                    end else if (tick) begin
                        cyc_left_q <= cyc_left_q - 15'h0001;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // sticky access error, write one to clear, a set in the same cycle wins
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            access_error_flag_q <= 1'b0;
        end else if (reject || (finish && abort_pend_q)) begin
            access_error_flag_q <= 1'b1;
        end else if (stat_wr && cpu_wdata[`FLA_ST_ERR]) begin
            access_error_flag_q <= 1'b0;
        end
    end

    // sticky done, same priority; a new launch clears it
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            done_q <= 1'b0;
        end else if (finish) begin
            done_q <= 1'b1;
        end else if (start || (stat_wr && cpu_wdata[`FLA_ST_DONE])) begin
            done_q <= 1'b0;
        end
    end

endmodule

// file: logic/fla_none.v
// no logic here: the whole block sits in the main design file

// file: tb/fla_props.sv
// assertion checker for the linear access block
`include "fla_regs.vh"
module fla_props (
    // clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // cpu side
    input wire logic [3:0]  cpu_addr,
    input wire logic        cpu_wr,
    input wire logic        cpu_rd,
    input wire logic [7:0]  cpu_wdata,
    input wire logic [7:0]  cpu_rdata_q,
    // array and sequencer side
    input wire logic [7:0]  mem_rdata,
    input wire logic [16:0] mem_addr,
    input wire logic [7:0]  mem_wdata_q,
    input wire logic        mem_wr_q,
    input wire logic        nvm_timing_tick_q,
    input wire logic        nvm_hv_on_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic [15:0] tick_cnt_q;
    // ticks seen while program voltage is on
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) tick_cnt_q <= 16'h0000;
        else if (!nvm_hv_on_q) tick_cnt_q <= 16'h0000;
        else if (nvm_timing_tick_q) tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
    AST_RD_DATA: assert property (cpu_rd && cpu_addr inside {4'h3, 4'h4, 4'h5} |=>
        cpu_rdata_q == $past(mem_rdata)) else $error("read data not the byte at the pointer");
    AST_RD_INC: assert property (cpu_rd && cpu_addr inside {4'h3, 4'h4} |=>
        mem_addr == $past(mem_addr) + 17'h0_0001) else $error("pointer did not advance after read");
    AST_WR_DATA: assert property (cpu_wr && cpu_addr inside {4'h3, 4'h4, 4'h5} |=>
        mem_wr_q && mem_wdata_q == $past(cpu_wdata)) else $error("array write missing or wrong");
    AST_WR_INC: assert property (cpu_wr && cpu_addr inside {4'h3, 4'h4} |=>
        mem_addr == $past(mem_addr) + 17'h0_0001) else $error("pointer did not advance after write");
    AST_PLAIN_HOLD: assert property ((cpu_rd || cpu_wr) && cpu_addr == `FLA_OFF_PLAIN |=>
        $stable(mem_addr)) else $error("plain port moved the pointer");
    AST_QUIET: assert property (!cpu_rd && !cpu_wr |=> $stable(mem_addr)) else $error("pointer moved idle");
    AST_ADD: assert property (cpu_wr && cpu_addr == `FLA_OFF_ADD |=> mem_addr ==
        $past(mem_addr) + {{9{$past(cpu_wdata[7])}}, $past(cpu_wdata)}) else $error("signed add wrong");
    AST_WR_CAUSE: assert property (mem_wr_q |-> $past(cpu_wr) &&
        $past(cpu_addr) inside {4'h3, 4'h4, 4'h5}) else $error("array write without data port write");
    AST_HV_TICKS: assert property ($fell(nvm_hv_on_q) |-> tick_cnt_q >= 16'h0003)
        else $error("program voltage dropped too early");
    AST_HV_ON_TICK: assert property ($fell(nvm_hv_on_q) |-> nvm_timing_tick_q)
        else $error("program voltage dropped off a timing tick");
    cover property (cpu_rd && cpu_addr == `FLA_OFF_WORDP);
    cover property (cpu_wr && cpu_addr == `FLA_OFF_ADD);
    cover property ($fell(nvm_hv_on_q));
    cover property (cpu_wr && cpu_addr == `FLA_OFF_CMD && cpu_wdata == `FLA_CMD_ABORT && nvm_hv_on_q);
endmodule

bind fla_linear_access fla_props i_props (.clk(clk), .reset_n(reset_n), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata_q(cpu_rdata_q), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
    .mem_wdata_q(mem_wdata_q), .mem_wr_q(mem_wr_q), .nvm_timing_tick_q(nvm_timing_tick_q),
    .nvm_hv_on_q(nvm_hv_on_q));

// file: tb/fla_mem_model.sv
// byte array standing behind the linear data ports
module fla_mem_model (
    // clock
    input wire logic        clk,
    // array port
    input wire logic [16:0] mem_addr,
    input wire logic [7:0]  mem_wdata_q,
    input wire logic        mem_wr_q,
    output wire logic [7:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  mem [0:131071];
    logic [16:0] addr_prev_q;
    // known pattern so reads of any place can be predicted
    initial for (int i = 0; i < 131072; i++) mem[i] = i[7:0] ^ i[15:8] ^ {7'h00, i[16]};
    // write pulse lands at the address held in the access cycle
    always @(posedge clk) begin
        addr_prev_q <= mem_addr;
        if (mem_wr_q) mem[addr_prev_q] <= mem_wdata_q;
    end
    assign mem_rdata = mem[mem_addr];
endmodule

// file: tb/tb.sv
// testbench for the linear access block
`include "fla_regs.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [3:0]  cpu_addr = 4'h0;
    logic        cpu_wr = 1'b0;
    logic        cpu_rd = 1'b0;
    logic [7:0]  cpu_wdata = 8'h00;
    logic [7:0]  cpu_rdata_q, mem_rdata, mem_wdata_q, nvm_op_q;
    logic [16:0] mem_addr, nvm_sector_q;
    logic        mem_wr_q, nvm_timing_tick_q, nvm_hv_on_q, nvm_eeprom_q;
    logic [7:0]  av [3] = '{8'h80, 8'h7F, 8'hFF};
    logic [16:0] pv [3] = '{17'h1_FF82, 17'h0_0001, 17'h0_0000};
    logic [7:0]  cc [3] = '{`FLA_CMD_BYTE, `FLA_CMD_SECT, `FLA_CMD_MASS};
    int          cy [3] = '{18, 8000, 40000};
    int          failures = 0;
    int          num_checks = 0;
    int          n;
    always #5 clk = ~clk;
    fla_linear_access i_dut (.clk(clk), .reset_n(reset_n), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
        .cpu_wdata(cpu_wdata), .cpu_rdata_q(cpu_rdata_q), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
        .mem_wdata_q(mem_wdata_q), .mem_wr_q(mem_wr_q), .nvm_timing_tick_q(nvm_timing_tick_q),
        .nvm_hv_on_q(nvm_hv_on_q), .nvm_op_q(nvm_op_q), .nvm_sector_q(nvm_sector_q), .nvm_eeprom_q(nvm_eeprom_q));
    fla_mem_model i_mem (.clk(clk), .mem_addr(mem_addr), .mem_wdata_q(mem_wdata_q), .mem_wr_q(mem_wr_q),
        .mem_rdata(mem_rdata));
    function automatic logic [7:0] iv(input logic [16:0] a);
        return a[7:0] ^ a[15:8] ^ {7'h00, a[16]};
    endfunction
    task automatic end_of_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // an idle cycle, then one strobe cycle
    task automatic acc(input logic r, input logic [3:0] a, input logic [7:0] d);
        @(negedge clk);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_rd = r;
        cpu_wr = !r;
        @(negedge clk);
        cpu_rd = 1'b0;
        cpu_wr = 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        acc(1'b0, a, d);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        acc(1'b1, a, 8'h00);
        chk("rdata", {9'h000, e}, {9'h000, cpu_rdata_q});
    endtask
    task automatic wait_hv(input logic lvl, output int c);
        c = 0;
        while (nvm_hv_on_q !== lvl) begin
            @(negedge clk);
            c++;
            if (c > 50000) begin
                failures++;
                $display("[ERR] hv expected %h seen %h", lvl, nvm_hv_on_q);
                end_of_test();
            end
        end
    endtask
    // launch a command and measure how long program voltage stands
    task automatic run_cmd(input logic [7:0] c, input int e);
        int t;
        wr(`FLA_OFF_CMD, c);
        wait_hv(1'b1, t);
        wait_hv(1'b0, t);
        chk("cycles", e[16:0], (t > e - 5 && t < e + 5) ? e[16:0] : t[16:0]);
        chk("op", {9'h000, c}, {9'h000, nvm_op_q});
        rd(`FLA_OFF_STAT, 8'h0A);
        wr(`FLA_OFF_STAT, 8'h02);
    endtask
    initial begin
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        // pointer load and wrap through both post-increment ports
        wr(`FLA_OFF_PTR2, 8'h01);
        wr(`FLA_OFF_PTR1, 8'hFF);
        wr(`FLA_OFF_PTR0, 8'hFE);
        chk("pointer", 17'h1_FFFE, mem_addr);
        rd(`FLA_OFF_PTR2, 8'h01);
        rd(`FLA_OFF_PTR1, 8'hFF);
        rd(`FLA_OFF_PTR0, 8'hFE);
        rd(`FLA_OFF_BYTEP, iv(17'h1_FFFE));
        rd(`FLA_OFF_WORDP, iv(17'h1_FFFF));
        chk("pointer", 17'h0_0000, mem_addr);
        rd(`FLA_OFF_PLAIN, iv(17'h0_0000));
        chk("pointer", 17'h0_0000, mem_addr);
        $display("test pointer done");
        // writes through all three ports, read back after stepping back
        wr(`FLA_OFF_WORDP, 8'hA5);
        wr(`FLA_OFF_BYTEP, 8'h5A);
        wr(`FLA_OFF_PLAIN, 8'h3C);
        chk("pointer", 17'h0_0002, mem_addr);
        wr(`FLA_OFF_ADD, 8'hFE);
        rd(`FLA_OFF_WORDP, 8'hA5);
        rd(`FLA_OFF_BYTEP, 8'h5A);
        rd(`FLA_OFF_PLAIN, 8'h3C);
        rd(`FLA_OFF_ADD, 8'h00);
        rd(4'h7, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wr(`FLA_OFF_ADD, av[i]);
            chk("pointer", pv[i], mem_addr);
        end
        $display("test ports done");
        // commands refused before the divider, then timed by it
        wr(`FLA_OFF_PTR2, 8'h01);
        wr(`FLA_OFF_PTR1, 8'hFF);
        wr(`FLA_OFF_PTR0, 8'hFE);
        wr(`FLA_OFF_CMD, `FLA_CMD_BYTE);
        rd(`FLA_OFF_STAT, 8'h01);
        chk("hv", 17'h0_0000, {16'h0000, nvm_hv_on_q});
        wr(`FLA_OFF_STAT, 8'h01);
        rd(`FLA_OFF_STAT, 8'h00);
        wr(`FLA_OFF_CLKDIV, 8'h01);
        wr(`FLA_OFF_CLKDIV, 8'h05);
        rd(`FLA_OFF_CLKDIV, 8'h01);
        rd(`FLA_OFF_STAT, 8'h08);
        // settle time before the first real command, timing ticks counted meanwhile
        n = 0;
        repeat (1000) begin
            @(negedge clk);
            if (nvm_timing_tick_q === 1'b1) n++;
        end
        chk("ticks", 17'h0_01F4, n[16:0]);
        for (int i = 0; i < 3; i++) begin
            run_cmd(cc[i], cy[i]);
            if (i == 1) chk("sector", 17'h1_FE00, nvm_sector_q);
            if (i == 1) chk("eeprom", 17'h0_0000, {16'h0000, nvm_eeprom_q});
        end
        $display("test commands done");
        // burst chain inside one 32-byte block, then across its boundary
        run_cmd(`FLA_CMD_BURST, 18);
        wr(`FLA_OFF_BYTEP, 8'h11);
        run_cmd(`FLA_CMD_BURST, 8);
        wr(`FLA_OFF_BYTEP, 8'h22);
        run_cmd(`FLA_CMD_BURST, 18);
        $display("test burst done");
        // blank check runs without program voltage, commands refused while busy
        wr(`FLA_OFF_CMD, `FLA_CMD_BLANK);
        rd(`FLA_OFF_STAT, 8'h0C);
        wr(`FLA_OFF_CMD, `FLA_CMD_BYTE);
        chk("hv", 17'h0_0000, {16'h0000, nvm_hv_on_q});
        repeat (20) @(negedge clk);
        rd(`FLA_OFF_STAT, 8'h0B);
        wr(`FLA_OFF_STAT, 8'h03);
        $display("test blank done");
        // eeprom sector erase cut short by an abort, both sector sizes
        wr(`FLA_OFF_PTR0, 8'h37);
        for (int i = 0; i < 2; i++) begin
            wr(`FLA_OFF_CTRL, {6'h00, i[0], 1'b1});
            rd(`FLA_OFF_CTRL, {6'h00, i[0], 1'b1});
            wr(`FLA_OFF_CMD, `FLA_CMD_SECT);
            chk("sector", (i == 0) ? 17'h0_0034 : 17'h0_0030, nvm_sector_q);
            chk("eeprom", 17'h0_0001, {16'h0000, nvm_eeprom_q});
            wr(`FLA_OFF_CMD, `FLA_CMD_ABORT);
            wait_hv(1'b0, n);
            chk("abort", 17'h0_0008, (n > 3 && n < 13) ? 17'h0_0008 : n[16:0]);
            rd(`FLA_OFF_STAT, 8'h0B);
            wr(`FLA_OFF_STAT, 8'h03);
        end
        $display("test abort done");
        end_of_test();
    end
endmodule
